//--- rtl/tws_event_shortcuts.sv
// The Wishbone interface to the registers was chosen for this implementation.
`timescale 1ns/1ps
// Contract
// - Suspended event only right after a read acknowledge, with suspend requested earlier.
// - Suspended event flag register at 0x148 shows the master entered suspension.
// - Shortcut A set: every byte boundary triggers the suspend task.
// - Shortcut B set: every byte boundary triggers the stop task.
// - Enable-set bit A: write one enables stopped interrupt; reads enable state.
// - Bits B to F enable received, sent, error, boundary, suspended interrupts.
// - Suspended interrupt fires only for a properly produced suspended event.
// - Shortcut and enable-set registers reset to zero.
// - Byte boundary event comes ahead of every byte sent or received.
module tws_event_shortcuts
	import tws_pkg::*;
(
	input  wire logic                 clk_i,
	input  wire logic                 rst_i,
	input  wire logic [WB_ADDR_W-1:0] adr_i,
	input  wire logic [WB_DATA_W-1:0] dat_i,
	input  wire logic [3:0]           sel_i,
	input  wire logic                 we_i,
	input  wire logic                 cyc_i,
	input  wire logic                 stb_i,
	output logic      [WB_DATA_W-1:0] dat_o,
	output logic                      ack_o,
	input  wire tws_engine_t          engine_i,
	output logic                      pause_link_o,
	output logic                      halt_link_o,
	output logic                      suspended_o,
	output logic                      irq_o
);

	logic               [SHORT_W-1:0] event_task_shortcuts_q;
	tws_evt_t                         inten_q;
	tws_evt_t                         status_q;
	logic                             susp_flag_q;
	logic                             susp_evt;
	logic                             armed;
	logic                             held;
	logic                             req_take;
	logic                             wr_low;
	tws_evt_t                         evt_now;
	logic               [WB_DATA_W-1:0] rd_data;

	function automatic logic hit(input logic [WB_ADDR_W-1:0] a, input logic [11:0] off);
		hit = (a[WB_ADDR_W-1:2] == off[11:2]);
	endfunction

	// Classic cycle: taken on the first edge with cyc and stb, ack for one cycle
	assign req_take = cyc_i && stb_i && !ack_o;
	assign wr_low   = req_take && we_i && sel_i[0];

	wire boundary_pause = engine_i.byte_boundary && event_task_shortcuts_q[SHORT_PAUSE_BIT];
	wire boundary_halt  = engine_i.byte_boundary && event_task_shortcuts_q[SHORT_HALT_BIT];

	tws_suspend_fsm u_susp (
		.clk_i          (clk_i),
		.rst_i          (rst_i),
		.request_i      (engine_i.suspend_task || boundary_pause),
		.read_ack_done_i(engine_i.read_ack_done),
		.resume_i       (engine_i.resume_task),
		.abort_i        (engine_i.stopped),
		.suspended_evt_o(susp_evt),
		.armed_o        (armed),
		.held_o         (held)
	);

	always_comb begin
		evt_now               = '0;
		evt_now.stopped       = engine_i.stopped;
		evt_now.byte_received = engine_i.byte_received;
		evt_now.byte_sent     = engine_i.byte_sent;
		evt_now.error         = engine_i.error;
		evt_now.byte_boundary = engine_i.byte_boundary;
		evt_now.suspended     = susp_evt;
	end

	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			ack_o <= 1'b0;
		end else begin
			ack_o <= req_take;
		end
	end

	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			event_task_shortcuts_q <= EVENT_TASK_SHORTCUTS_RST;
		end else if (wr_low && hit(adr_i, OFF_EVENT_TASK_SHORTCUTS)) begin
			event_task_shortcuts_q <= dat_i[SHORT_W-1:0];
		end
	end

	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			inten_q <= INTEN_RST;
		end else if (wr_low && hit(adr_i, OFF_INTEN_SET)) begin
			// Ones set, zeros leave the bit alone
			inten_q <= inten_q | dat_i[EVT_W-1:0];
		end
	end

	// Sticky status, write one to clear; a new event wins over the clear
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			status_q <= STATUS_RST;
		end else if (wr_low && hit(adr_i, OFF_EVT_STATUS)) begin
			status_q <= (status_q & ~dat_i[EVT_W-1:0]) | evt_now;
		end else begin
			status_q <= status_q | evt_now;
		end
	end

	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			susp_flag_q <= 1'b0;
		end else if (susp_evt) begin
			susp_flag_q <= 1'b1;
		end else if (wr_low && hit(adr_i, OFF_SUSP_FLAG)) begin
			susp_flag_q <= dat_i[0];
		end
	end

	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			pause_link_o <= 1'b0;
			halt_link_o  <= 1'b0;
		end else begin
			pause_link_o <= boundary_pause;
			halt_link_o  <= boundary_halt;
		end
	end

	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			irq_o       <= 1'b0;
			suspended_o <= 1'b0;
		end else begin
			irq_o       <= |(status_q & inten_q);
			suspended_o <= held;
		end
	end

	always_comb begin
		rd_data = '0;
		if (hit(adr_i, OFF_SUSP_FLAG)) begin
			rd_data[0] = susp_flag_q;
		end else if (hit(adr_i, OFF_EVENT_TASK_SHORTCUTS)) begin
			rd_data[SHORT_W-1:0] = event_task_shortcuts_q;
		end else if (hit(adr_i, OFF_INTEN_SET)) begin
			rd_data[EVT_W-1:0] = inten_q;
		end else if (hit(adr_i, OFF_EVT_STATUS)) begin
			rd_data[EVT_W-1:0] = status_q;
		end else if (hit(adr_i, OFF_LINK_STATE)) begin
			rd_data[STATE_ARMED_BIT] = armed;
			rd_data[STATE_HELD_BIT]  = held;
		end
	end

	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			dat_o <= '0;
		end else if (req_take && !we_i) begin
			dat_o <= rd_data;
		end
	end

	default clocking cb @(posedge clk_i); endclocking
	default disable iff (rst_i);

	// A read acknowledge in the arming cycle itself already consumed the request
	sequence s_arm;
		armed && !engine_i.stopped && !engine_i.read_ack_done;
	endsequence

	sequence s_read_ack;
		engine_i.read_ack_done && !engine_i.stopped;
	endsequence

	susp_event_cause_a: assert property (s_arm ##1 s_read_ack ##1 1'b1 |-> susp_evt)
		else $error("suspended event missing after armed read acknowledge");
	susp_event_only_a: assert property ($rose(susp_evt) |-> $past(engine_i.read_ack_done) && $past(armed))
		else $error("suspended event without read acknowledge or request");
	susp_flag_set_a: assert property (susp_evt |=> susp_flag_q)
		else $error("suspended flag not set by event");
	pause_short_a: assert property (pause_link_o |-> $past(engine_i.byte_boundary && event_task_shortcuts_q[SHORT_PAUSE_BIT]))
		else $error("pause task without enabled shortcut boundary");
	halt_short_a: assert property (engine_i.byte_boundary && event_task_shortcuts_q[SHORT_HALT_BIT] |=> halt_link_o)
		else $error("stop task missing on boundary");
	inten_set_a: assert property (wr_low && hit(adr_i, OFF_INTEN_SET) && dat_i[0] |=> inten_q.stopped)
		else $error("stopped interrupt enable not set");
	inten_keep_a: assert property ((inten_q & $past(inten_q)) == $past(inten_q))
		else $error("interrupt enable bit cleared");
	irq_susp_a: assert property ($rose(status_q.suspended) |-> $past(susp_evt))
		else $error("suspended status set without event");
	reset_zero_a: assert property ($past(rst_i) |-> event_task_shortcuts_q == EVENT_TASK_SHORTCUTS_RST && inten_q == INTEN_RST)
		else $error("registers not zero after reset");
	boundary_stat_a: assert property (engine_i.byte_boundary |=> status_q.byte_boundary)
		else $error("boundary event not recorded");
	irq_level_a: assert property (|(status_q & inten_q) |=> irq_o)
		else $error("interrupt not raised for enabled event");
	ack_single_a: assert property (ack_o |=> !ack_o)
		else $error("ack held longer than one cycle");

endmodule // tws_event_shortcuts

//--- rtl/tws_pkg.sv
package tws_pkg;

	localparam int          WB_ADDR_W         = 12;
	localparam int          WB_DATA_W         = 32;
	localparam int          EVT_W             = 6;
	localparam int          SHORT_W           = 2;

	// Register byte offsets
	localparam logic [11:0] OFF_SUSP_FLAG     = 12'h148;
	localparam logic [11:0] OFF_EVENT_TASK_SHORTCUTS        = 12'h200;
	localparam logic [11:0] OFF_INTEN_SET     = 12'h304;
	localparam logic [11:0] OFF_EVT_STATUS    = 12'h400;
	localparam logic [11:0] OFF_LINK_STATE    = 12'h404;

	// Field positions
	localparam int          SHORT_PAUSE_BIT   = 0;
	localparam int          SHORT_HALT_BIT    = 1;
	localparam int          STATE_ARMED_BIT   = 0;
	localparam int          STATE_HELD_BIT    = 1;

	// Values after reset
	localparam logic [SHORT_W-1:0] EVENT_TASK_SHORTCUTS_RST = 2'h0;
	localparam logic [EVT_W-1:0]   INTEN_RST  = 6'h00;
	localparam logic [EVT_W-1:0]   STATUS_RST = 6'h00;

	// Event set: bit 0 stopped up to bit 5 suspended, same layout in the enable-set and status registers
	typedef struct packed {
		logic suspended;
		logic byte_boundary;
		logic error;
		logic byte_sent;
		logic byte_received;
		logic stopped;
	} tws_evt_t;

	// One-cycle strobes from the protocol engine and task logic
	typedef struct packed {
		logic stopped;
		logic byte_received;
		logic byte_sent;
		logic error;
		logic byte_boundary;
		logic read_ack_done;
		logic suspend_task;
		logic resume_task;
	} tws_engine_t;

	typedef enum logic [1:0] {
		SUSP_IDLE,
		SUSP_ARMED,
		SUSP_HELD
	} tws_susp_state_t;

endpackage

//--- rtl/tws_suspend_fsm.sv
`timescale 1ns/1ps
module tws_suspend_fsm
	import tws_pkg::*;
(
	input  wire logic clk_i,
	input  wire logic rst_i,
	input  wire logic request_i,
	input  wire logic read_ack_done_i,
	input  wire logic resume_i,
	input  wire logic abort_i,
	output logic      suspended_evt_o,
	output logic      armed_o,
	output logic      held_o
);

	tws_susp_state_t state_q;
	tws_susp_state_t state_d;
	logic            evt_d;

	always_comb begin
		state_d = state_q;
		evt_d   = 1'b0;
		case (state_q)
			SUSP_IDLE: begin
				if (request_i) begin
					state_d = SUSP_ARMED;
				end
			end
			SUSP_ARMED: begin
				// Event only after the read acknowledge of an earlier request
				if (read_ack_done_i) begin
					state_d = SUSP_HELD;
					evt_d   = 1'b1;
				end
			end
			SUSP_HELD: begin
				if (resume_i) begin
					state_d = SUSP_IDLE;
				end
			end
			default: begin
				state_d = SUSP_IDLE;
			end
		endcase
		if (abort_i) begin
			state_d = SUSP_IDLE;
			evt_d   = 1'b0;
		end
	end

	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			state_q <= SUSP_IDLE;
		end else begin
			state_q <= state_d;
		end
	end

	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			suspended_evt_o <= 1'b0;
			armed_o         <= 1'b0;
			held_o          <= 1'b0;
		end else begin
			suspended_evt_o <= evt_d;
			armed_o         <= (state_d == SUSP_ARMED);
			held_o          <= (state_d == SUSP_HELD);
		end
	end

endmodule // tws_suspend_fsm

//--- tb/tb.sv
`timescale 1ns/1ps
`define CHK(n, e, g) begin total_checks++; if ((g) !== (e)) begin err_count++; $display("[ERR] %s exp %0h got %0h", n, e, g); end end
module tb
	import tws_pkg::*;
;
	logic                 clk_i = 1'b0;
	logic                 rst_i = 1'b1;
	logic [WB_ADDR_W-1:0] adr_i = '0;
	logic [WB_DATA_W-1:0] dat_i = '0;
	logic [WB_DATA_W-1:0] dat_o;
	logic [WB_DATA_W-1:0] rd;
	logic [3:0]           sel_i = 4'h0;
	logic [3:0]           wsel = 4'hF;
	logic                 we_i = 1'b0;
	logic                 cyc_i = 1'b0;
	logic                 stb_i = 1'b0;
	logic                 ack_o;
	logic                 pause_link_o;
	logic                 halt_link_o;
	logic                 suspended_o;
	logic                 irq_o;
	tws_engine_t          engine;
	int                   err_count = 0;
	int                   total_checks = 0;

	always #25 clk_i = ~clk_i;

	tws_engine_model tws_engine_model_inst (.clk_i(clk_i), .engine_o(engine));

	tws_event_shortcuts tws_event_shortcuts_inst (
		.clk_i(clk_i), .rst_i(rst_i), .adr_i(adr_i), .dat_i(dat_i), .sel_i(sel_i), .we_i(we_i),
		.cyc_i(cyc_i), .stb_i(stb_i), .dat_o(dat_o), .ack_o(ack_o), .engine_i(engine),
		.pause_link_o(pause_link_o), .halt_link_o(halt_link_o), .suspended_o(suspended_o), .irq_o(irq_o)
	);

	task automatic wb(input logic w, input logic [11:0] a, input logic [31:0] d);
		@(posedge clk_i);
		cyc_i <= 1'b1;
		stb_i <= 1'b1;
		we_i  <= w;
		adr_i <= a;
		dat_i <= d;
		sel_i <= wsel;
		// Only the watchdog ends a wait for ack
		do begin
			@(posedge clk_i);
		end while (ack_o !== 1'b1);
		rd = dat_o;
		cyc_i <= 1'b0;
		stb_i <= 1'b0;
		we_i  <= 1'b0;
	endtask

	task automatic rdchk(input logic [11:0] a, input logic [31:0] e, input string n);
		wb(1'b0, a, 32'h0);
		`CHK(n, e, rd)
	endtask

	task automatic wait_clk(input int n);
		repeat (n) @(posedge clk_i);
		#1;
	endtask

	task automatic t_reset;
		rdchk(OFF_EVENT_TASK_SHORTCUTS, 32'h0, "event_task_shortcuts_rst");
		rdchk(OFF_INTEN_SET, 32'h0, "inten_rst");
		rdchk(12'h010, 32'h0, "unmapped");
		$display("test reset done");
	endtask

	task automatic t_event_task_shortcuts;
		tws_engine_model_inst.pulse(8'h08);
		#1;
		`CHK("pause_off", 1'b0, pause_link_o)
		`CHK("halt_off", 1'b0, halt_link_o)
		wb(1'b1, OFF_EVENT_TASK_SHORTCUTS, 32'h3);
		rdchk(OFF_EVENT_TASK_SHORTCUTS, 32'h3, "event_task_shortcuts_rb");
		tws_engine_model_inst.pulse(8'h08);
		#1;
		`CHK("pause_on", 1'b1, pause_link_o)
		`CHK("halt_on", 1'b1, halt_link_o)
		rdchk(OFF_EVT_STATUS, 32'h10, "bb_status");
		rdchk(OFF_LINK_STATE, 32'h1, "short_armed");
		wb(1'b1, OFF_EVENT_TASK_SHORTCUTS, 32'h0);
		// Byte lane 0 deselected: the write is acked but ignored
		wsel = 4'hE;
		wb(1'b1, OFF_EVENT_TASK_SHORTCUTS, 32'h3);
		wsel = 4'hF;
		rdchk(OFF_EVENT_TASK_SHORTCUTS, 32'h0, "event_task_shortcuts_nosel");
		// Stopped strobe cancels the suspend armed by the shortcut
		tws_engine_model_inst.pulse(8'h80);
		wait_clk(2);
		`CHK("irq_masked", 1'b0, irq_o)
		$display("test shortcuts done");
	endtask

	task automatic t_inten;
		wb(1'b1, OFF_INTEN_SET, 32'h01);
		rdchk(OFF_INTEN_SET, 32'h01, "inten_a");
		wb(1'b1, OFF_INTEN_SET, 32'h00);
		rdchk(OFF_INTEN_SET, 32'h01, "inten_w0");
		wb(1'b1, OFF_INTEN_SET, 32'h3E);
		rdchk(OFF_INTEN_SET, 32'h3F, "inten_all");
		`CHK("irq_on", 1'b1, irq_o)
		wb(1'b1, OFF_EVT_STATUS, 32'h3F);
		wait_clk(2);
		`CHK("irq_clr", 1'b0, irq_o)
		tws_engine_model_inst.pulse(8'h70);
		rdchk(OFF_EVT_STATUS, 32'h0E, "evt_status");
		`CHK("irq_evt", 1'b1, irq_o)
		wb(1'b1, OFF_EVT_STATUS, 32'h3F);
		wait_clk(2);
		`CHK("irq_evt_clr", 1'b0, irq_o)
		$display("test enables done");
	endtask

	task automatic t_suspend;
		tws_engine_model_inst.pulse(8'h04);
		wait_clk(3);
		`CHK("susp_noreq", 1'b0, suspended_o)
		`CHK("irq_noreq", 1'b0, irq_o)
		tws_engine_model_inst.pulse(8'h02);
		rdchk(OFF_LINK_STATE, 32'h1, "armed_state");
		tws_engine_model_inst.pulse(8'h04);
		wait_clk(3);
		`CHK("susp_set", 1'b1, suspended_o)
		`CHK("irq_susp", 1'b1, irq_o)
		rdchk(OFF_LINK_STATE, 32'h2, "held_state");
		rdchk(OFF_SUSP_FLAG, 32'h1, "susp_flag");
		tws_engine_model_inst.pulse(8'h01);
		wait_clk(2);
		`CHK("susp_resume", 1'b0, suspended_o)
		$display("test suspend done");
	endtask

	task automatic t_midreset;
		wb(1'b1, OFF_EVENT_TASK_SHORTCUTS, 32'h3);
		@(posedge clk_i);
		rst_i <= 1'b1;
		repeat (3) @(posedge clk_i);
		rst_i <= 1'b0;
		rdchk(OFF_EVENT_TASK_SHORTCUTS, 32'h0, "event_task_shortcuts_rerst");
		rdchk(OFF_INTEN_SET, 32'h0, "inten_rerst");
		`CHK("irq_rerst", 1'b0, irq_o)
		$display("test mid reset done");
	endtask

	task automatic test_done;
		$display("checks %0d mismatches %0d", total_checks, err_count);
		if (err_count == 0 && total_checks > 0)
			$display("SIMULATION PASSED");
		else
			$display("SIMULATION FAILED");
		$finish;
	endtask

	initial begin
		repeat (3) @(posedge clk_i);
		rst_i <= 1'b0;
		t_reset();
		t_event_task_shortcuts();
		t_inten();
		t_suspend();
		t_midreset();
		test_done();
	end

	initial begin
		#100000;
		err_count++;
		test_done();
	end
endmodule // tb

//--- tb/tws_engine_model.sv
`timescale 1ns/1ps
module tws_engine_model
	import tws_pkg::*;
(
	input  wire logic  clk_i,
	output tws_engine_t engine_o
);
	initial engine_o = '0;

	// One-cycle strobe, launched and dropped just after rising edges
	task automatic pulse(input tws_engine_t v);
		@(posedge clk_i);
		engine_o <= v;
		@(posedge clk_i);
		engine_o <= '0;
	endtask
endmodule // tws_engine_model
